// ### hw/rfc_pkg.sv
// Package for the receive filter control register block
// What this block does
// - A set iscsi_filter_off bit turns iSCSI header filtering off; clear keeps it on.
// - The iscsi_header_dwords field gives the iSCSI header length in 32-bit words for packet split.
// - A set nfs_write_filter_off bit stops header filtering of NFS write requests.
// - A set nfs_read_filter_off bit stops header filtering of NFS read replies.
// - The nfs_protocol_version field selects NFS version 2, 3 or 4, with the fourth code reserved.
// - A set ipv6_filter_off bit stops packet filtering of IPv6 packets.
// - A set ipv6_checksum_off bit stops receive checksum offload on IPv6 packets.
// - A set ack_irq_accel_off bit stops TCP ACKs from accelerating the interrupt.
// - With ack_payload_check_off clear an ACK needs the ACK flag and no payload; set, the flag alone.
// - A set frag_header_split_off bit stops header split of fragmented IP packets.
// - Extended status is written when ext_status_on is set or the split descriptor format is used.
// - With NFS parsing turned off by either NFS bit, an NFS packet is classed as iSCSI.
package rfc_pkg;
  localparam logic [15:0] RFC_ADDR_RFCTRL = 16'h5008;
  localparam logic [31:0] RFC_RESET_VAL   = 32'h0000_0000;
  localparam logic [31:0] RFC_IMPL_MASK   = 32'h0000_FFFF;
  localparam int          RFC_BIT_ISCSI   = 0;
  localparam int          RFC_BIT_NFSW    = 6;
  localparam int          RFC_BIT_NFSR    = 7;
  localparam int          RFC_BIT_V6F     = 10;
  localparam int          RFC_BIT_V6X     = 11;
  localparam int          RFC_BIT_ACKI    = 12;
  localparam int          RFC_BIT_ACKD    = 13;
  localparam int          RFC_BIT_FRAG    = 14;
  localparam int          RFC_BIT_EXST    = 15;
  localparam int          RFC_DW_LSB      = 1;
  localparam int          RFC_DW_MSB      = 5;
  localparam int          RFC_VER_LSB     = 8;
  localparam int          RFC_VER_MSB     = 9;
  localparam logic [1:0]  RFC_NFS_V2      = 2'h0;
  localparam logic [1:0]  RFC_NFS_V3      = 2'h1;
  localparam logic [1:0]  RFC_NFS_V4      = 2'h2;

  // Decoded controls driven to the receive path
  typedef struct packed {
    logic       iscsi_filter_on;
    logic [4:0] iscsi_header_dwords;
    logic       nfs_write_filter_on;
    logic       nfs_read_filter_on;
    logic       nfs_v2;
    logic       nfs_v3;
    logic       nfs_v4;
    logic       nfs_protocol_version_reserved;
    logic       ipv6_filter_on;
    logic       ipv6_checksum_on;
    logic       ack_irq_accel_on;
    logic       ack_payload_check_on;
    logic       frag_header_split_on;
    logic       ext_status_on;
  } rfc_ctrl_t;

  // Per-packet classification inputs from the receive parser
  typedef struct packed {
    logic valid;
    logic is_tcp;
    logic tcp_ack_flag;
    logic has_payload;
    logic is_nfs;
    logic is_iscsi;
    logic split_desc;
  } rfc_pkt_t;

  // Per-packet classification results
  typedef struct packed {
    logic valid;
    logic iscsi_class;
    logic ack_packet;
    logic ack_irq_accel;
    logic ext_status_write;
  } rfc_cls_t;

  typedef enum logic [1:0] {
    RFC_IDLE   = 2'b01,
    RFC_ACCESS = 2'b10
  } rfc_state_t;
endpackage

// ### hw/rfc_classify.sv
// Per-packet classifier steered by the receive filter controls
`timescale 1ns/1ps
`default_nettype none
module rfc_classify
  import rfc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      clk_en,
  input  wire rfc_ctrl_t ctrl,
  input  wire rfc_pkt_t  pkt,
  output rfc_cls_t       cls_r
);
  rfc_cls_t cls_nxt;
  logic     ack_pkt;

  always_comb begin
    ack_pkt = pkt.is_tcp && pkt.tcp_ack_flag && (!ctrl.ack_payload_check_on || !pkt.has_payload);
    cls_nxt.valid            = pkt.valid;
    cls_nxt.iscsi_class      = pkt.is_iscsi ||
                               (pkt.is_nfs && !(ctrl.nfs_write_filter_on && ctrl.nfs_read_filter_on));
    cls_nxt.ack_packet       = ack_pkt;
    cls_nxt.ack_irq_accel    = ack_pkt && ctrl.ack_irq_accel_on;
    cls_nxt.ext_status_write = ctrl.ext_status_on || pkt.split_desc;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cls_r <= '0;
    end else if (clk_en) begin
      cls_r <= cls_nxt;
    end
  end
endmodule
`default_nettype wire

// ### hw/rfc_top.sv
// APB slave holding the receive filter control register
`timescale 1ns/1ps
`default_nettype none
module rfc_top
  import rfc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire rfc_pkt_t    pkt,
  output rfc_ctrl_t        ctrl_r,
  output rfc_cls_t         cls
);
  logic        rst_s1_r;
  logic        rst_n_r;
  logic [31:0] rfctrl_r;
  logic [31:0] rfctrl_nxt;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        hit;
  logic        access;
  rfc_state_t  state_r;
  rfc_ctrl_t   ctrl_nxt;

  function automatic logic [31:0] rfc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reset release synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  assign hit    = (paddr == RFC_ADDR_RFCTRL);
  assign access = psel && penable && (state_r == RFC_ACCESS);
  // Zero wait states: the access phase completes at its first edge
  assign pready  = psel && penable;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= RFC_IDLE;
    end else if (clk_en) begin
      case (state_r)
        RFC_IDLE:   state_r <= (psel && !penable) ? RFC_ACCESS : RFC_IDLE;
        RFC_ACCESS: state_r <= (psel && !penable) ? RFC_ACCESS : RFC_IDLE;
        default:    state_r <= RFC_IDLE;
      endcase
    end
  end

  assign rfctrl_nxt = rfc_merge(rfctrl_r, pwdata, pstrb) & RFC_IMPL_MASK;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rfctrl_r <= RFC_RESET_VAL;
    end else if (clk_en && access && pwrite && hit) begin
      rfctrl_r <= rfctrl_nxt;
    end
  end

  // Read data and error answer, captured in setup so they are stable in access
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (clk_en && psel && !penable) begin
      prdata_r  <= (!pwrite && hit) ? (rfctrl_r & RFC_IMPL_MASK) : '0;
      pslverr_r <= !hit;
    end
  end

  always_comb begin
    ctrl_nxt.iscsi_filter_on      = !rfctrl_r[RFC_BIT_ISCSI];
    ctrl_nxt.iscsi_header_dwords  = rfctrl_r[RFC_DW_MSB:RFC_DW_LSB];
    ctrl_nxt.nfs_write_filter_on  = !rfctrl_r[RFC_BIT_NFSW];
    ctrl_nxt.nfs_read_filter_on   = !rfctrl_r[RFC_BIT_NFSR];
    ctrl_nxt.nfs_v2               = rfctrl_r[RFC_VER_MSB:RFC_VER_LSB] == RFC_NFS_V2;
    ctrl_nxt.nfs_v3               = rfctrl_r[RFC_VER_MSB:RFC_VER_LSB] == RFC_NFS_V3;
    ctrl_nxt.nfs_v4               = rfctrl_r[RFC_VER_MSB:RFC_VER_LSB] == RFC_NFS_V4;
    ctrl_nxt.nfs_protocol_version_reserved     = !(ctrl_nxt.nfs_v2 || ctrl_nxt.nfs_v3 || ctrl_nxt.nfs_v4);
    ctrl_nxt.ipv6_filter_on       = !rfctrl_r[RFC_BIT_V6F];
    ctrl_nxt.ipv6_checksum_on     = !rfctrl_r[RFC_BIT_V6X];
    ctrl_nxt.ack_irq_accel_on     = !rfctrl_r[RFC_BIT_ACKI];
    ctrl_nxt.ack_payload_check_on = !rfctrl_r[RFC_BIT_ACKD];
    ctrl_nxt.frag_header_split_on = !rfctrl_r[RFC_BIT_FRAG];
    ctrl_nxt.ext_status_on        = rfctrl_r[RFC_BIT_EXST];
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= '0;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  rfc_classify u_classify (
    .clk    (ref_clk),
    .rst_n  (rst_n_r),
    .clk_en (clk_en),
    .ctrl   (ctrl_r),
    .pkt    (pkt),
    .cls_r  (cls)
  );
endmodule
`default_nettype wire

// ### testbench/rfc_properties.sv
// Port checks for the receive filter control block
`timescale 1ns/1ps
`default_nettype none
module rfc_properties
  import rfc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire rfc_pkt_t    pkt,
  input wire rfc_ctrl_t   ctrl_r,
  input wire rfc_cls_t    cls
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic ack_e = pkt.is_tcp & pkt.tcp_ack_flag & (!ctrl_r.ack_payload_check_on | !pkt.has_payload);
  wire logic isc_e = pkt.is_iscsi | (pkt.is_nfs & !(ctrl_r.nfs_write_filter_on & ctrl_r.nfs_read_filter_on));
  wire logic ext_e = ctrl_r.ext_status_on | pkt.split_desc;
  sequence s_rd; psel && penable && !pwrite && paddr == RFC_ADDR_RFCTRL; endsequence
  // Packet taken while the controls hold still
  sequence s_pk; pkt.valid && clk_en ##1 $stable(ctrl_r); endsequence
  a_rsvd_zero: assert property (s_rd |-> prdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");
  a_low_bits: assert property (s_rd |-> prdata[7:0] == {!ctrl_r.nfs_read_filter_on,
    !ctrl_r.nfs_write_filter_on, ctrl_r.iscsi_header_dwords, !ctrl_r.iscsi_filter_on}) else $error("low decode");
  a_ver_decode: assert property (s_rd |-> {ctrl_r.nfs_protocol_version_reserved, ctrl_r.nfs_v4,
    ctrl_r.nfs_v3, ctrl_r.nfs_v2} == 4'h1 << prdata[9:8]) else $error("version decode");
  a_high_bits: assert property (s_rd |-> prdata[15:10] == {ctrl_r.ext_status_on,
    ~{ctrl_r.frag_header_split_on, ctrl_r.ack_payload_check_on, ctrl_r.ack_irq_accel_on,
    ctrl_r.ipv6_checksum_on, ctrl_r.ipv6_filter_on}}) else $error("high decode");
  a_iscsi_class: assert property (s_pk |-> cls.iscsi_class == $past(isc_e))
    else $error("iscsi class");
  a_ack_class: assert property (s_pk |-> cls.ack_packet == $past(ack_e))
    else $error("ack class");
  a_ack_accel: assert property (s_pk |-> cls.ack_irq_accel == ($past(ack_e) && ctrl_r.ack_irq_accel_on))
    else $error("ack accel");
  a_ext_write: assert property (s_pk |-> cls.valid && cls.ext_status_write == $past(ext_e))
    else $error("ext status");
endmodule
bind rfc_top rfc_properties u_rfc_properties (.*);
`default_nettype wire

// ### testbench/receive_filter_control_test.sv
// Self-checking bench for the receive filter control block
`timescale 1ns/1ps
`default_nettype none
module receive_filter_control_test;
  import rfc_pkg::*;
  logic        ref_clk = 0, reset_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, err;
  rfc_pkt_t    pkt = '0;
  rfc_ctrl_t   ctrl_r;
  rfc_cls_t    cls;
  int          miscompares = 0, checks = 0;
  always #20 ref_clk = ~ref_clk;
  rfc_top u_rfc_top (.*);
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge ref_clk);
    penable <= 1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin miscompares++; wrap_up(); end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  function automatic rfc_ctrl_t exp_ctrl(logic [15:0] v);
    return '{~v[0], v[5:1], ~v[6], ~v[7], v[9:8] == 0, v[9:8] == 1, v[9:8] == 2, v[9:8] == 3,
             ~v[10], ~v[11], ~v[12], ~v[13], ~v[14], v[15]};
  endfunction
  function automatic rfc_cls_t exp_cls(rfc_pkt_t p, logic [15:0] v);
    logic a;
    a = p.is_tcp & p.tcp_ack_flag & (v[13] | ~p.has_payload);
    return '{1'b1, p.is_iscsi | (p.is_nfs & (v[6] | v[7])), a, a & ~v[12], v[15] | p.split_desc};
  endfunction
  initial begin
    logic [31:0] d, v;
    rfc_pkt_t    p;
    d = $urandom(32'h99B3);
    repeat (5) @(posedge ref_clk);
    reset_n <= 1;
    repeat (4) @(posedge ref_clk);
    apb(0, RFC_ADDR_RFCTRL, 0, 0);
    chk("reset value", RFC_RESET_VAL, rd);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      if (i < 4) d[9:8] = i[1:0];
      d[31:16] = 16'h0000;
      apb(1, RFC_ADDR_RFCTRL, d, 4'hF);
      v = d & RFC_IMPL_MASK;
      apb(0, RFC_ADDR_RFCTRL, 0, 0);
      chk("readback", v, rd);
      chk("ctrl", 32'(exp_ctrl(v[15:0])), 32'(ctrl_r));
      p = 7'($urandom);
      p.valid = 1;
      pkt <= p;
      @(posedge ref_clk);
      #1 chk("cls", 32'(exp_cls(p, v[15:0])), 32'(cls));
    end
    $display("test random done");
    @(posedge ref_clk);
    clk_en <= 0;
    pkt <= '0;
    repeat (3) @(posedge ref_clk);
    #1 chk("freeze cls", 32'(exp_cls(p, v[15:0])), 32'(cls));
    @(posedge ref_clk);
    clk_en <= 1;
    $display("test freeze done");
    apb(1, RFC_ADDR_RFCTRL, 0, 4'hF);
    apb(1, RFC_ADDR_RFCTRL, 32'hFFFF_FFFF, 4'hE);
    apb(1, RFC_ADDR_RFCTRL, 0, 4'h0);
    apb(1, 16'h5000, 0, 4'hF);
    chk("unmapped err", 1, err);
    apb(0, 16'h5000, 0, 0);
    chk("unmapped data", 0, rd);
    apb(0, RFC_ADDR_RFCTRL, 0, 0);
    chk("strobe word", 32'h0000_FF00, rd);
    chk("strobe err", 0, err);
    $display("test strobe done");
    wrap_up();
  end
endmodule
`default_nettype wire
